// [hdl/ethernet_port_wake_detect.sv]
/*
  two-port receive wake detection with a transmit fcs appender and an avalon-mm slave.
  assumes mii nibble receive pins from the phy, sampled by ref_clk (250 mhz), and a
  link level pin per port; transmit bytes arrive on ref_clk from the user side.
*/
// Contract
// - two independent ports, port 0 wan and port 1 lan, each with wake logic.
// - accept frames up to 2000 bytes on wan, 9k bytes on lan.
// - append fcs to transmitted frames and check fcs of received frames.
// - received frames with errors are dropped, not delivered.
// - receive and transmit buffering sized 8k/8k wan, 24k/22k lan.
// - wake request on link change, wake frame, or wake pattern frame.
// - up to four wake frame crc definitions per port, matched by crc value.
// - with pattern mode on, scan frames addressed here, multicast or broadcast.
// - only frames with valid addresses and good crc are pattern candidates.
// - sequence is sixteen back-to-back copies of the 48-bit station address.
// - address copies must directly follow six bytes of ff.
// - sequence may start at any byte offset of the frame.
// - broadcast frames qualify when the address copies match this station.
// - no protocol type restriction beyond the sequence itself.
// - valid pattern frame with mode on signals power management to wake.
// - scanned frame without the sequence causes no wake action.
`timescale 1ns/1ns
module ethernet_port_wake_detect import wake_pkg::*; #(
  parameter int WAN_MAX_LEN = MAX_LEN_WAN,
  parameter int LAN_MAX_LEN = MAX_LEN_LAN
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [3:0]            avs_byteenable,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // phy receive and link pins
  input  wire mii_rx_s [NUM_PORTS-1:0] mii_rx,
  input  wire logic [NUM_PORTS-1:0]  link_up,
  // transmit byte streams
  input  wire tx_byte_s [NUM_PORTS-1:0] tx_in,
  output logic      [NUM_PORTS-1:0]  tx_ready,
  output tx_byte_s  [NUM_PORTS-1:0]  tx_out,
  // power management
  output logic                       irq,
  output logic      [NUM_PORTS-1:0]  wake_request
);

  // a frame must fit the port's receive buffer as well as its length limit
  localparam int WAN_LIM = (WAN_MAX_LEN < RX_BUF_WAN) ? WAN_MAX_LEN : RX_BUF_WAN;
  localparam int LAN_LIM = (LAN_MAX_LEN < RX_BUF_LAN) ? LAN_MAX_LEN : RX_BUF_LAN;
  localparam int NUM_WCRC = NUM_PORTS * NUM_WAKE_CRC;

  typedef struct packed {
    port_s [NUM_PORTS-1:0]        p;
    logic  [CTRL_W-1:0]           ctrl;
    logic  [STATUS_W-1:0]         status;
    logic  [STATUS_W-1:0]         mask;
    logic  [NUM_WCRC-1:0]         wcrc_en;
    logic  [NUM_WCRC-1:0][31:0]   wcrc;
    logic  [NUM_PORTS-1:0][47:0]  sta;
    logic                         ack;
    logic  [31:0]                 rdata;
  } top_s;

  top_s                             s;
  top_s                             n;
  logic [NUM_PORTS-1:0]             frame_end;
  logic [NUM_PORTS-1:0]             frame_good;
  logic [NUM_PORTS-1:0]             da_ok;
  logic [NUM_PORTS-1:0]             wfr_hit;
  logic [NUM_PORTS-1:0]             found;
  logic [NUM_PORTS-1:0][CNT_W-1:0]  lim;
  logic [NUM_PORTS-1:0][31:0]       rx_crc_nxt;
  logic [NUM_PORTS-1:0][31:0]       tx_crc_nxt;
  logic [STATUS_W-1:0]              ev;
  logic [STATUS_W-1:0]              clr;
  logic [31:0]                      wm;
  logic [31:0]                      wv;
  logic [31:0]                      rd;
  logic                             req;

  // ----------------------------------------------------------------
  // per-port datapath instances
  // ----------------------------------------------------------------
  // one receive and transmit slice per port, alike except for the frame length limit
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    wake_crc32 u_rx_crc (
      .crc_in  (s.p[g].crc),
      .data    (s.p[g].rx_byte),
      .crc_out (rx_crc_nxt[g])
    );
    wake_crc32 u_tx_crc (
      .crc_in  (s.p[g].tx_crc_x ^ CRC_INIT),
      .data    (tx_in[g].data),
      .crc_out (tx_crc_nxt[g])
    );
    wake_pattern_scan u_scan (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .start    (s.p[g].sof),
      .byte_vld (s.p[g].byte_vld),
      .rx_byte  (s.p[g].rx_byte),
      .station  (s.sta[g]),
      .found    (found[g])
    );
    assign tx_ready[g]     = (s.p[g].fcs_left == 3'h0);
    assign tx_out[g]       = s.p[g].tx_out;
    assign wake_request[g] = |(s.status[g*CAUSE_STRIDE +: CAUSE_STRIDE]
                               & s.mask[g*CAUSE_STRIDE +: CAUSE_STRIDE]);
    assign lim[g]          = (g == WAN_PORT) ? CNT_W'(WAN_LIM) : CNT_W'(LAN_LIM);
  end

  // ----------------------------------------------------------------
  // frame verdicts and wake events
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      frame_end[i]  = s.p[i].in_frame & ~s.p[i].dv2;
      // crc residue, whole bytes and length bounds decide a good frame
      frame_good[i] = s.p[i].sfd & ~s.p[i].nib_hi & (s.p[i].crc == CRC_RESIDUE)
                      & (s.p[i].cnt >= CNT_W'(MIN_LEN)) & (s.p[i].cnt <= lim[i]);
      // own address, or group bit set, which covers broadcast
      da_ok[i]      = (s.p[i].da == s.sta[i]) | s.p[i].da[40];
      wfr_hit[i]    = 1'b0;
      for (int k = 0; k < NUM_WAKE_CRC; k++) begin
        if (s.wcrc_en[i*NUM_WAKE_CRC+k] && s.p[i].fcs == s.wcrc[i*NUM_WAKE_CRC+k]) begin
          wfr_hit[i] = 1'b1;
        end
      end
      ev[i*CAUSE_STRIDE+CAUSE_LINK] = s.p[i].lnk2 ^ s.p[i].lnk3;
      ev[i*CAUSE_STRIDE+CAUSE_WFR]  = frame_end[i] & frame_good[i] & da_ok[i] & wfr_hit[i]
                                      & s.ctrl[CTRL_WFR_EN+i];
      // pattern wake only with the mode bit that software sets before sleep
      ev[i*CAUSE_STRIDE+CAUSE_PAT]  = frame_end[i] & frame_good[i] & da_ok[i] & found[i]
                                      & s.ctrl[CTRL_PAT_EN+i];
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd = '0;
    case (avs_address)
      REG_CTRL:    rd[CTRL_W-1:0]   = s.ctrl;
      REG_STATUS:  rd[STATUS_W-1:0] = s.status;
      REG_MASK:    rd[STATUS_W-1:0] = s.mask;
      REG_WCRC_EN: rd[NUM_WCRC-1:0] = s.wcrc_en;
      default:     rd = '0;
    endcase
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (avs_address == REG_STA_LO0 + 7'(STA_STRIDE * i)) rd = s.sta[i][31:0];
      if (avs_address == REG_STA_HI0 + 7'(STA_STRIDE * i)) rd = {16'h0, s.sta[i][47:32]};
      if (avs_address == REG_DROP0 + 7'(WORD_BYTES * i))   rd = {16'h0, s.p[i].drops};
    end
    for (int j = 0; j < NUM_WCRC; j++) begin
      if (avs_address == REG_WCRC0 + 7'(WORD_BYTES * j)) rd = s.wcrc[j];
    end
  end

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s.ack;
  assign avs_readdata    = s.rdata;
  assign irq             = |(s.status & s.mask);
  assign wm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wv = avs_writedata & wm;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n   = s;
    clr = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      // pins cross by two flops; the third flop only feeds edge detection
      n.p[i].rxc1     = mii_rx[i].clk;
      n.p[i].rxc2     = s.p[i].rxc1;
      n.p[i].rxc3     = s.p[i].rxc2;
      n.p[i].dv1      = mii_rx[i].dv;
      n.p[i].dv2      = s.p[i].dv1;
      n.p[i].rxd1     = mii_rx[i].d;
      n.p[i].rxd2     = s.p[i].rxd1;
      n.p[i].lnk1     = link_up[i];
      n.p[i].lnk2     = s.p[i].lnk1;
      n.p[i].lnk3     = s.p[i].lnk2;
      n.p[i].byte_vld = 1'b0;
      n.p[i].sof      = 1'b0;
      if (s.p[i].byte_vld) begin
        n.p[i].crc = rx_crc_nxt[i];
        n.p[i].fcs = {s.p[i].rx_byte, s.p[i].fcs[31:8]};
        if (s.p[i].cnt != '1) begin
          n.p[i].cnt = s.p[i].cnt + CNT_W'(1);
        end
        if (s.p[i].cnt < CNT_W'(ADDR_BYTES)) begin
          n.p[i].da = {s.p[i].da[39:0], s.p[i].rx_byte};
        end
      end
      // sample on the falling rx clock edge, mid-way between phy updates
      if (s.p[i].rxc3 && !s.p[i].rxc2 && s.p[i].dv2) begin
        if (!s.p[i].in_frame) begin
          n.p[i].in_frame = 1'b1;
          n.p[i].sfd      = 1'b0;
          n.p[i].nib_hi   = 1'b0;
          n.p[i].cnt      = '0;
          n.p[i].crc      = CRC_INIT;
        end else if (!s.p[i].sfd) begin
          if (s.p[i].rxd2 == SFD_NIBBLE) begin
            n.p[i].sfd = 1'b1;
            n.p[i].sof = 1'b1;
          end
        end else if (!s.p[i].nib_hi) begin
          n.p[i].low    = s.p[i].rxd2;
          n.p[i].nib_hi = 1'b1;
        end else begin
          n.p[i].rx_byte  = {s.p[i].rxd2, s.p[i].low};
          n.p[i].byte_vld = 1'b1;
          n.p[i].nib_hi   = 1'b0;
        end
      end
      if (frame_end[i]) begin
        n.p[i].in_frame = 1'b0;
        if (!frame_good[i]) begin
          n.p[i].drops = s.p[i].drops + 16'h1;
        end
      end
      // crc kept xor'd with its seed so the all-zero reset is a ready seed
      n.p[i].tx_out.valid = 1'b0;
      n.p[i].tx_out.last  = 1'b0;
      if (s.p[i].fcs_left != 3'h0) begin
        n.p[i].tx_out.valid = 1'b1;
        n.p[i].tx_out.data  = s.p[i].tx_fcs[7:0];
        n.p[i].tx_out.last  = (s.p[i].fcs_left == 3'h1);
        n.p[i].tx_fcs       = s.p[i].tx_fcs >> 8;
        n.p[i].fcs_left     = s.p[i].fcs_left - 3'h1;
      end else if (tx_in[i].valid) begin
        n.p[i].tx_out.valid = 1'b1;
        n.p[i].tx_out.data  = tx_in[i].data;
        n.p[i].tx_crc_x     = tx_crc_nxt[i] ^ CRC_INIT;
        if (tx_in[i].last) begin
          n.p[i].tx_crc_x = '0;
          n.p[i].tx_fcs   = ~tx_crc_nxt[i];
          n.p[i].fcs_left = 3'(FCS_BYTES);
        end
      end
    end
    // one wait state: request taken on the first edge, answered on the second
    n.ack = req & ~s.ack;
    if (req && !s.ack) begin
      n.rdata = rd;
    end
    if (avs_write && s.ack) begin
      case (avs_address)
        REG_CTRL:    n.ctrl    = (s.ctrl & ~wm[CTRL_W-1:0]) | wv[CTRL_W-1:0];
        REG_STATUS:  clr       = wv[STATUS_W-1:0];
        REG_MASK:    n.mask    = (s.mask & ~wm[STATUS_W-1:0]) | wv[STATUS_W-1:0];
        REG_WCRC_EN: n.wcrc_en = (s.wcrc_en & ~wm[NUM_WCRC-1:0]) | wv[NUM_WCRC-1:0];
        default:     n.ctrl    = s.ctrl;
      endcase
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (avs_address == REG_STA_LO0 + 7'(STA_STRIDE * i)) begin
          n.sta[i][31:0] = (s.sta[i][31:0] & ~wm) | wv;
        end
        if (avs_address == REG_STA_HI0 + 7'(STA_STRIDE * i)) begin
          n.sta[i][47:32] = (s.sta[i][47:32] & ~wm[15:0]) | wv[15:0];
        end
      end
      for (int j = 0; j < NUM_WCRC; j++) begin
        if (avs_address == REG_WCRC0 + 7'(WORD_BYTES * j)) begin
          n.wcrc[j] = (s.wcrc[j] & ~wm) | wv;
        end
      end
    end
    // a new event outranks a clear in the same cycle
    n.status = (s.status & ~clr) | ev;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
    sequence fcs_tail;
      (!tx_ready[g]) [*4] ##1 tx_ready[g];
    endsequence

    pat_wake_a: assert property (
      (frame_end[g] && frame_good[g] && da_ok[g] && found[g] && s.ctrl[CTRL_PAT_EN+g])
      |=> s.status[g*CAUSE_STRIDE+CAUSE_PAT])
      else $error("pattern frame did not raise wake");
    pat_gate_a: assert property (
      $rose(s.status[g*CAUSE_STRIDE+CAUSE_PAT])
      |-> $past(frame_good[g] && da_ok[g] && found[g]))
      else $error("pattern wake without good addressed frame");
    len_gate_a: assert property (
      $rose(s.status[g*CAUSE_STRIDE+CAUSE_WFR]) |-> $past(s.p[g].cnt <= lim[g]))
      else $error("wake from an oversized frame");
    drop_cnt_a: assert property (
      (frame_end[g] && !frame_good[g]) |=> s.p[g].drops == $past(s.p[g].drops) + 16'h1)
      else $error("bad frame not counted as dropped");
    link_ev_a: assert property (
      $changed(s.p[g].lnk2) |=> s.status[g*CAUSE_STRIDE+CAUSE_LINK])
      else $error("link change did not set status");
    wfr_gate_a: assert property (
      $rose(s.status[g*CAUSE_STRIDE+CAUSE_WFR]) |-> $past(wfr_hit[g] && frame_good[g]))
      else $error("wake frame status without crc match");
    tx_fcs_a: assert property (
      (tx_in[g].valid && tx_ready[g] && tx_in[g].last) |=> fcs_tail)
      else $error("fcs tail not four bytes");
  end

endmodule

// [hdl/wake_pkg.sv]
/*
  constants, field layouts and carrier types for the two-port receive wake block.
  assumes a single 250 mhz system clock; phy pins are sampled, never used as clocks.
*/
package wake_pkg;

  // ----------------------------------------------------------------
  // ports and frame limits
  // ----------------------------------------------------------------
  localparam int NUM_PORTS    = 2;
  localparam int WAN_PORT     = 0;
  localparam int LAN_PORT     = 1;
  localparam int MAX_LEN_WAN  = 2000;
  localparam int MAX_LEN_LAN  = 9216;
  localparam int MIN_LEN      = 64;
  localparam int RX_BUF_WAN   = 8192;
  localparam int TX_BUF_WAN   = 8192;
  localparam int RX_BUF_LAN   = 24576;
  localparam int TX_BUF_LAN   = 22528;
  localparam int CNT_W        = 14;
  localparam int NUM_WAKE_CRC = 4;
  localparam int SYNC_LEN     = 6;
  localparam int ADDR_BYTES   = 6;
  localparam int ADDR_REPS    = 16;
  localparam int FCS_BYTES    = 4;

  localparam logic [7:0]  SYNC_BYTE   = 8'hff;
  localparam logic [3:0]  SFD_NIBBLE  = 4'hd;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 7;
  localparam logic [6:0] REG_CTRL    = 7'h00;
  localparam logic [6:0] REG_STATUS  = 7'h04;
  localparam logic [6:0] REG_MASK    = 7'h08;
  localparam logic [6:0] REG_WCRC_EN = 7'h0c;
  localparam logic [6:0] REG_STA_LO0 = 7'h10;
  localparam logic [6:0] REG_STA_HI0 = 7'h14;
  localparam logic [6:0] REG_DROP0   = 7'h20;
  localparam logic [6:0] REG_WCRC0   = 7'h40;
  localparam int         STA_STRIDE  = 8;
  localparam int         WORD_BYTES  = 4;

  localparam int CTRL_W       = 4;
  localparam int CTRL_PAT_EN  = 0;
  localparam int CTRL_WFR_EN  = 2;
  localparam int STATUS_W     = 8;
  localparam int CAUSE_STRIDE = 4;
  localparam int CAUSE_LINK   = 0;
  localparam int CAUSE_WFR    = 1;
  localparam int CAUSE_PAT    = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       clk;
    logic       dv;
    logic [3:0] d;
  } mii_rx_s;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } tx_byte_s;

  typedef enum logic [2:0] {
    SCAN_HUNT  = 3'b001,
    SCAN_MATCH = 3'b010,
    SCAN_DONE  = 3'b100
  } scan_state_e;

  typedef struct packed {
    logic             rxc1, rxc2, rxc3;
    logic             dv1, dv2;
    logic [3:0]       rxd1, rxd2;
    logic             lnk1, lnk2, lnk3;
    logic             in_frame, sfd, nib_hi, byte_vld, sof;
    logic [3:0]       low;
    logic [7:0]       rx_byte;
    logic [CNT_W-1:0] cnt;
    logic [31:0]      crc;
    logic [31:0]      fcs;
    logic [47:0]      da;
    logic [15:0]      drops;
    logic [31:0]      tx_crc_x;
    logic [31:0]      tx_fcs;
    logic [2:0]       fcs_left;
    tx_byte_s         tx_out;
  } port_s;

endpackage

// [hdl/wake_crc32.sv]
/*
  one byte step of the reflected ethernet crc-32, purely combinational.
  assumes the caller holds the running value and feeds bytes least bit first.
*/
`timescale 1ns/1ns
module wake_crc32 import wake_pkg::*; (
  // running value and byte
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  // updated value
  output logic      [31:0] crc_out
);

  always_comb begin
    crc_out = crc_in;
    for (int b = 0; b < 8; b++) begin
      crc_out = (crc_out >> 1) ^ ((crc_out[0] ^ data[b]) ? CRC_POLY : 32'h0);
    end
  end

endmodule

// [hdl/wake_pattern_scan.sv]
/*
  per-port scanner for a sync run followed by repeated station addresses.
  assumes start pulses once per frame before its first byte, bytes at most one per cycle.
*/
`timescale 1ns/1ns
module wake_pattern_scan import wake_pkg::*; (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // byte stream
  input  wire logic        start,
  input  wire logic        byte_vld,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [47:0] station,
  // result
  output logic             found
);

  typedef struct packed {
    scan_state_e st;
    logic [2:0]  ff_cnt;
    logic [2:0]  idx;
    logic [3:0]  rep;
    logic        found;
  } scan_s;

  scan_s      s;
  scan_s      n;
  logic [7:0] expect_byte;

  // ----------------------------------------------------------------
  // scan
  // ----------------------------------------------------------------
  // every byte is inspected, so the sequence may sit at any offset
  // no ethertype or upper-layer check is made
  always_comb begin
    n = s;
    expect_byte = station[(ADDR_BYTES - 1 - int'(s.idx)) * 8 +: 8];
    if (start) begin
      n.st     = SCAN_HUNT;
      n.ff_cnt = 3'h0;
      n.idx    = 3'h0;
      n.found  = 1'b0;
    end else if (byte_vld) begin
      case (s.st)
        SCAN_HUNT: begin
          if (s.ff_cnt == 3'(SYNC_LEN) && rx_byte == expect_byte) begin
            n.st  = SCAN_MATCH;
            n.idx = 3'h1;
            n.rep = 4'h0;
          end else if (rx_byte == SYNC_BYTE) begin
            if (s.ff_cnt != 3'(SYNC_LEN)) begin
              n.ff_cnt = s.ff_cnt + 3'h1;
            end
          end else begin
            n.ff_cnt = 3'h0;
          end
        end
        SCAN_MATCH: begin
          if (rx_byte == expect_byte) begin
            if (s.idx == 3'(ADDR_BYTES - 1)) begin
              n.idx = 3'h0;
              if (s.rep == 4'(ADDR_REPS - 1)) begin
                n.st    = SCAN_DONE;
                n.found = 1'b1;
              end else begin
                n.rep = s.rep + 4'h1;
              end
            end else begin
              n.idx = s.idx + 3'h1;
            end
          end else begin
            // a broken copy restarts the hunt rather than ending the frame
            n.st     = SCAN_HUNT;
            n.idx    = 3'h0;
            n.ff_cnt = (rx_byte == SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        end
        SCAN_DONE: begin
          n.st = SCAN_DONE;
        end
        default: begin
          n.st = SCAN_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign found = s.found;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sync_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s.st == SCAN_HUNT && n.st == SCAN_MATCH) |-> s.ff_cnt == 3'(SYNC_LEN))
    else $error("address match entered without full sync run");
  addr_reps_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(s.found) |-> $past(s.rep) == 4'hf && $past(rx_byte) == station[7:0])
    else $error("pattern found before sixteen address copies");
  hunt_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (s.st == SCAN_MATCH && byte_vld && !start && rx_byte != expect_byte) |=> s.st == SCAN_HUNT)
    else $error("mismatch did not restart the hunt");

endmodule

// [tb/phy_model.sv]
/* phy receive model: sends byte frames as mii nibbles with preamble and fcs.
   assumes a 125 ns link clock that stands still between frames. */
`timescale 1ns/1ns
module phy_model import wake_pkg::*; (
  output mii_rx_s rx
);
  initial rx = '0;
  // fcs of a byte list as it goes on the wire: inverted reflected crc, low byte first
  function automatic logic [31:0] fcs_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [31:0] c;
    logic [3:0]  n[$];
    c = fcs_of(q) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
    repeat (15) n.push_back(4'h5);
    n.push_back(SFD_NIBBLE);
    foreach (q[i]) n = {n, q[i][3:0], q[i][7:4]};
    foreach (n[i]) begin
      rx <= '{1'b1, 1'b1, n[i]};
      #62 rx.clk <= 1'b0;
      #63;
    end
    // released: data shows the inverse so a stale nibble cannot pass
    rx <= '{1'b0, 1'b0, ~n[n.size()-1]};
    #250;
  endtask
endmodule

// [tb/ethernet_port_wake_detect_tb_top.sv]
/* bench: avalon master tasks, one phy model per port, scenario tasks.
   assumes the wake package and a 250 mhz ref_clk. */
`timescale 1ns/1ns
module ethernet_port_wake_detect_tb_top import wake_pkg::*;;
  localparam logic [47:0] STA = 48'h0a1b2c3d4e5f;
  logic                   ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, irq;
  logic [6:0]             avs_address = '0;
  logic [31:0]            avs_writedata = '0, avs_readdata, rdat;
  logic                   avs_waitrequest;
  logic [1:0]             link_up = '0, wake_request, tx_ready;
  tx_byte_s [1:0]         tx_in = '0, tx_out;
  wire mii_rx_s [1:0]     mii_rx;
  logic [7:0]             fq[$];
  int                     failures = 0, checks_done = 0, cyc = 0;

  always #2 ref_clk = ~ref_clk;
  phy_model phy0 (.rx(mii_rx[0]));
  phy_model phy1 (.rx(mii_rx[1]));
  ethernet_port_wake_detect uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hf), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mii_rx(mii_rx), .link_up(link_up),
    .tx_in(tx_in), .tx_ready(tx_ready), .tx_out(tx_out), .irq(irq),
    .wake_request(wake_request));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk(rdat, exp);
  endtask

  task automatic mk(input logic [47:0] da, input int reps);
    fq = {};
    for (int k = 0; k < 6; k++) fq.push_back(da[47-8*k -: 8]);
    fq = {fq, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h08, 8'h00};
    repeat (6) fq.push_back(8'hff);
    fq = {fq, STA[47:40], 8'h00};
    repeat (7) fq.push_back(8'hff);
    repeat (reps) for (int k = 0; k < 6; k++) fq.push_back(STA[47-8*k -: 8]);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(REG_STATUS, 32'h0);
    rd(7'h7c, 32'h0);
    bus(1'b1, REG_CTRL, 32'hf);
    rd(REG_CTRL, 32'hf);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, REG_STA_LO0 + 7'(p*STA_STRIDE), STA[31:0]);
      bus(1'b1, REG_STA_HI0 + 7'(p*STA_STRIDE), {16'h0, STA[47:32]});
    end
    bus(1'b1, REG_MASK, 32'h77);
    $display("register test done");
  endtask

  task t_tx;
    logic [31:0] f;
    fq = {8'ha5};
    f = phy0.fcs_of(fq);
    @(posedge ref_clk);
    tx_in[0] <= '{1'b1, 1'b1, 8'ha5};
    @(posedge ref_clk);
    tx_in[0] <= '0;
    @(posedge ref_clk);
    chk({21'h0, tx_ready[0], tx_out[0]}, {21'h0, 3'b010, 8'ha5});
    for (int b = 0; b < 4; b++) begin
      @(posedge ref_clk);
      chk({21'h0, tx_ready[0], tx_out[0]}, {21'h0, b == 3, 1'b1, b == 3, f[8*b +: 8]});
    end
    $display("transmit test done");
  endtask

  task t_wfr;
    mk(STA, 15);
    bus(1'b1, REG_WCRC0, phy0.fcs_of(fq));
    bus(1'b1, REG_WCRC_EN, 32'h1);
    phy0.send(fq, 1'b0);
    rd(REG_STATUS, 32'h2);
    chk({30'h0, wake_request}, 32'h1);
    bus(1'b1, REG_STATUS, 32'h2);
    $display("wake frame test done");
  endtask

  task t_pattern;
    mk(STA, 16);
    phy0.send(fq, 1'b0);
    rd(REG_STATUS, 32'h4);
    chk({30'h0, wake_request}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, REG_STATUS, 32'h4);
    rd(REG_STATUS, 32'h0);
    $display("pattern test done");
  endtask

  task t_reject;
    mk(STA, 16);
    phy0.send(fq, 1'b1);
    rd(REG_STATUS, 32'h0);
    rd(REG_DROP0, 32'h1);
    mk(STA, 15);
    phy0.send(fq, 1'b0);
    rd(REG_STATUS, 32'h0);
    mk(48'h0a1b2c3d4e00, 16);
    phy0.send(fq, 1'b0);
    rd(REG_STATUS, 32'h0);
    $display("reject test done");
  endtask

  task t_bcast;
    mk(48'hffffffffffff, 16);
    phy1.send(fq, 1'b0);
    rd(REG_STATUS, 32'h40);
    chk({30'h0, wake_request}, 32'h2);
    bus(1'b1, REG_STATUS, 32'h40);
    $display("broadcast test done");
  endtask

  task t_link;
    link_up <= 2'b10;
    repeat (10) @(posedge ref_clk);
    rd(REG_STATUS, 32'h10);
    chk({30'h0, wake_request}, 32'h2);
    $display("link test done");
  endtask

  task finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_tx;
    t_pattern;
    t_reject;
    t_wfr;
    t_bcast;
    t_link;
    finish_test;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      finish_test;
    end
  end
endmodule
